//--- design/aods_cfg.svh
// Purpose: Constants for the converter output stage and its capture end
// Assumes: One 100 MHz clock stands for the sample clock
// Notes on behaviour
// R1: One 12-bit word per sample clock edge
// R2: Standard select low CMOS, high LVDS
// R3: Port timing select only matters in CMOS
// R4: Full-scale select sets range, not timing
// R5: Undriven select inputs read as low
// R6: Interleaved ports update half output cycle apart
// R7: Sync high freezes data and data clock; the code freezes them in CMOS only
// R8: Sync falling edge marks sample N, port A
// R9: Interleaved latency 14 cycles on both ports
// R10: Parallel latency A 15, B 14 cycles
// R11: Capture end holds sync static in LVDS
// R12: One common sync, once at reset; the capture end also syncs again on sync_req_i
// R13: CMOS data clock is sample clock halved
// R14: LVDS data clock toggles every sample clock
// R15: Stabilizer locks on sample clock rising edge
// R16: Stabilizer unusable below about 30 MHz
// R17: Capture discards data 1.5 to 5 us after speedup
// R18: Stabilizer always on, never disabled
// R19: Format select low offset binary, high twos
// R20: Twos complement by inverting the MSB
`ifndef AODS_CFG_SVH
`define AODS_CFG_SVH
`define AODS_DATA_W        12
`define AODS_LAT_A_PAR     15
`define AODS_LAT_B         14
`define AODS_LAT_INT       14
`define AODS_CLK_MHZ       100
`define AODS_DCS_MIN_MHZ   30
`define AODS_SETTLE_NS     5000
`define AODS_SETTLE_CYC    ((`AODS_SETTLE_NS * `AODS_CLK_MHZ) / 1000)
`define AODS_FS_HI_MV      768
`define AODS_FS_LO_MV      1536
`endif

//--- design/aods_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Constants come from aods_cfg.svh
// Notes: None
`include "aods_cfg.svh"
package aods_pkg;
    typedef logic [`AODS_DATA_W-1:0] aods_word_t;
    typedef enum logic {AODS_CMOS, AODS_LVDS} aods_std_t;
    typedef enum logic {AODS_WAIT, AODS_RUN} aods_cap_t;
endpackage

//--- design/aods_link_if.sv
// Purpose: Pins between converter output stage and capture logic
// Assumes: Single clock domain
// Notes: Sync is a pair driven by the capture end
`timescale 1ns/100ps
interface aods_link_if;
    import aods_pkg::*;
    aods_word_t port_a;
    aods_word_t port_b;
    logic       data_clock_out_pos;
    logic       data_clock_out_neg;
    logic       sync_in_pos;
    logic       sync_in_neg;
    modport dev (output port_a, port_b, data_clock_out_pos, data_clock_out_neg,
                 input sync_in_pos, sync_in_neg);
    modport cap (input port_a, port_b, data_clock_out_pos, data_clock_out_neg,
                 output sync_in_pos, sync_in_neg);
endinterface

//--- design/aods_dev.sv
// Purpose: Output demux, sync and data clock of a 12-bit converter
// Assumes: clk_i is the sample clock; sample_i is the quantized word
// Notes: Select inputs are expected tied low when unused
`timescale 1ns/100ps
`include "aods_cfg.svh"
module aods_dev #(
    parameter int DATA_W = `AODS_DATA_W
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    // Converter core
    input  wire aods_pkg::aods_word_t sample_i,
    // Static selects
    input  wire logic              format_select_pin_i,
    input  wire logic              output_standard_select_i,
    input  wire logic              port_timing_select_i,
    input  wire logic              full_scale_select_i,
    // Status
    output logic                   full_scale_low_range_o,
    output logic                   dcs_active_o,
    // Link
    aods_link_if.dev               link
);
    import aods_pkg::*;
    localparam int DEPTH = `AODS_LAT_A_PAR;

    initial
    begin
        if (DATA_W != `AODS_DATA_W)
            $error("DATA_W must match the word type");
    end

    // ---------------------------------------------
    // Pipeline and sync
    // ---------------------------------------------
    aods_word_t pipe_r [DEPTH];
    aods_word_t pipe_nxt [DEPTH];
    aods_word_t a_r, a_nxt, b_r, b_nxt;
    logic       ph_r, ph_nxt, dclk_r, dclk_nxt, sync_d_r, frz;
    aods_std_t  std_sel;

    // R5: unused selects are tied low, giving the low-level modes
    // R2: standard decode
    assign std_sel = output_standard_select_i ? AODS_LVDS : AODS_CMOS;
    // R7: freeze on high sync, CMOS only
    assign frz = (std_sel == AODS_CMOS) && link.sync_in_pos && !link.sync_in_neg;
    // R4: range flag, no timing effect
    assign full_scale_low_range_o = full_scale_select_i;
    // R15: stabilizer locked; R16 R18 always on
    assign dcs_active_o = 1'b1;

    always_comb
    begin
        aods_word_t w;
        w = sample_i;
        // R19: format select; R20 MSB inversion
        if (format_select_pin_i)
            w[DATA_W-1] = ~sample_i[DATA_W-1];
        pipe_nxt[0] = w;
        for (int i = 1; i < DEPTH; i++)
            pipe_nxt[i] = pipe_r[i-1];
        a_nxt    = a_r;
        b_nxt    = b_r;
        ph_nxt   = ph_r;
        dclk_nxt = dclk_r;
        // R8: falling sync edge marks sample N on A
        if (sync_d_r && !link.sync_in_pos && std_sel == AODS_CMOS)
            ph_nxt = 1'b0;
        else if (!frz)
            ph_nxt = ~ph_r;
        if (!frz)
        begin
            if (std_sel == AODS_LVDS)
            begin
                // R14: data clock toggles every sample clock, one word per edge
                dclk_nxt = ~dclk_r;
                a_nxt    = pipe_r[`AODS_LAT_B-1];
            end
            else
            begin
                // R13: halved data clock
                dclk_nxt = ph_r;
                // R3: timing select in CMOS only
                if (port_timing_select_i)
                begin
                    // R6 R9: interleaved, alternate updates
                    if (ph_r)
                        a_nxt = pipe_r[`AODS_LAT_INT-1];
                    else
                        b_nxt = pipe_r[`AODS_LAT_INT-1];
                end
                else if (!ph_r)
                begin
                    // R10: parallel A 15, B 14
                    a_nxt = pipe_r[`AODS_LAT_A_PAR-1];
                    b_nxt = pipe_r[`AODS_LAT_B-1];
                end
            end
        end
    end

    // R1: one word per edge
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
                pipe_r[i] <= '0;
            a_r      <= '0;
            b_r      <= '0;
            ph_r     <= 1'b0;
            dclk_r   <= 1'b0;
            sync_d_r <= 1'b0;
        end
        else
        begin
            pipe_r   <= pipe_nxt;
            a_r      <= a_nxt;
            b_r      <= b_nxt;
            ph_r     <= ph_nxt;
            dclk_r   <= dclk_nxt;
            sync_d_r <= link.sync_in_pos;
        end
    end

    assign link.port_a             = a_r;
    assign link.port_b             = b_r;
    assign link.data_clock_out_pos = dclk_r;
    assign link.data_clock_out_neg = ~dclk_r;
endmodule

//--- design/aods_cap.sv
// Purpose: Capture end: drives sync, latches port words
// Assumes: Same clock as the device model
// Notes: Settle count after clock speedup is a parameter
`timescale 1ns/100ps
`include "aods_cfg.svh"
module aods_cap #(
    parameter int SETTLE_CYC = `AODS_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    // User side
    input  wire logic              lvds_mode_i,
    input  wire logic              sync_req_i,
    input  wire logic              clk_raised_i,
    output aods_pkg::aods_word_t   word_a_o,
    output aods_pkg::aods_word_t   word_b_o,
    output logic                   valid_o,
    // Link
    aods_link_if.cap               link
);
    import aods_pkg::*;

    initial
    begin
        if (SETTLE_CYC < 1)
            $error("SETTLE_CYC must be at least one");
    end

    // ---------------------------------------------
    // Sync and capture
    // ---------------------------------------------
    aods_cap_t  st_r, st_nxt;
    aods_word_t a_r, a_nxt, b_r, b_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic       v_r, v_nxt, dck_d_r;

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        a_nxt   = a_r;
        b_nxt   = b_r;
        v_nxt   = v_r;
        // R12: one sync after reset, or on request
        if (sync_req_i)
            st_nxt = AODS_WAIT;
        else if (st_r == AODS_WAIT)
            st_nxt = AODS_RUN;
        // R17: discard after clock speedup
        if (clk_raised_i)
            cnt_nxt = 32'(SETTLE_CYC);
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 32'd1;
        if (link.data_clock_out_pos != dck_d_r)
        begin
            a_nxt = link.port_a;
            b_nxt = link.port_b;
        end
        v_nxt = (st_r == AODS_RUN) && (cnt_r == '0);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r    <= AODS_WAIT;
            cnt_r   <= '0;
            a_r     <= '0;
            b_r     <= '0;
            v_r     <= 1'b0;
            dck_d_r <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            a_r     <= a_nxt;
            b_r     <= b_nxt;
            v_r     <= v_nxt;
            dck_d_r <= link.data_clock_out_pos;
        end
    end

    // R8 R11: sync high while waiting, low static in LVDS
    assign link.sync_in_pos = !lvds_mode_i && (st_r == AODS_WAIT);
    assign link.sync_in_neg = !link.sync_in_pos;
    assign word_a_o = a_r;
    assign word_b_o = b_r;
    assign valid_o  = v_r;
endmodule

//--- tb/aods_sva.sv
// Purpose: Link checks between both ends
// Assumes: One clock domain
// Notes: Sees link signals only
`timescale 1ns/100ps
module aods_sva (
    // Clock and reset
    input wire logic                 clk_i,
    input wire logic                 nrst_i,
    // Link
    input wire aods_pkg::aods_word_t port_a,
    input wire aods_pkg::aods_word_t port_b,
    input wire logic                 data_clock_out_pos,
    input wire logic                 data_clock_out_neg,
    input wire logic                 sync_in_pos,
    input wire logic                 sync_in_neg
);
    import aods_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_dclk_legs: assert property (data_clock_out_pos != data_clock_out_neg)
        else $error("data clock legs equal");
    chk_sync_legs: assert property (sync_in_pos != sync_in_neg)
        else $error("sync legs equal");
    chk_hold_a: assert property (sync_in_pos && $past(sync_in_pos) |-> $stable(port_a))
        else $error("port a moved while held");
    chk_hold_b: assert property (sync_in_pos && $past(sync_in_pos) |-> $stable(port_b))
        else $error("port b moved while held");
    chk_hold_dclk: assert property (sync_in_pos && $past(sync_in_pos)
        |-> $stable(data_clock_out_pos)) else $error("data clock moved while held");
    chk_dclk_start: assert property ($fell(sync_in_pos)
        |-> ##[1:3] $changed(data_clock_out_pos)) else $error("data clock not started");
    chk_dclk_rate: assert property (!sync_in_pos [*4] |-> $changed(data_clock_out_pos)
        || $past(data_clock_out_pos) != $past(data_clock_out_pos, 2))
        else $error("data clock stalled");
    chk_sync_once: assert property ($fell(sync_in_pos) |-> !sync_in_pos [*4])
        else $error("sync bounced");
endmodule

//--- tb/tb_adc_output_demux_sync.sv
// Purpose: Both ends joined, user sides driven
// Assumes: Short settle count
// Notes: Sample word counts up by 3
`timescale 1ns/100ps
module tb_adc_output_demux_sync;
    import aods_pkg::*;
    logic       clk_i, nrst_i, fmt, std, tim, fs, fs_lo, dcs, lvds, sreq, craise, valid;
    aods_word_t sample = 12'h000;
    aods_word_t wa, wb;
    aods_word_t hist [0:4095];
    int         n_mismatch, comparisons;
    int         cyc = 0;
    aods_link_if link ();
    aods_dev aods_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .sample_i(sample),
        .format_select_pin_i(fmt), .output_standard_select_i(std),
        .port_timing_select_i(tim), .full_scale_select_i(fs),
        .full_scale_low_range_o(fs_lo), .dcs_active_o(dcs), .link(link));
    aods_cap #(.SETTLE_CYC(4)) aods_cap_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .lvds_mode_i(lvds), .sync_req_i(sreq), .clk_raised_i(craise),
        .word_a_o(wa), .word_b_o(wb), .valid_o(valid), .link(link));
    aods_sva aods_sva_i (.clk_i(clk_i), .nrst_i(nrst_i), .port_a(link.port_a),
        .port_b(link.port_b), .data_clock_out_pos(link.data_clock_out_pos),
        .data_clock_out_neg(link.data_clock_out_neg),
        .sync_in_pos(link.sync_in_pos), .sync_in_neg(link.sync_in_neg));
    task automatic note(input logic bad, input string m);
        comparisons++;
        if (bad !== 1'b0)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic chk_word(input aods_word_t g, input aods_word_t e, input string m);
        note(g !== e, m);
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        note(g !== e, m);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic f, input logic s, input logic t, input int n);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        fmt <= f;
        std <= s;
        lvds <= s;
        tim <= t;
        repeat (n) @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask
    task automatic wait_sync(output int k);
        logic prev;
        prev = 1'b1;
        k = -1;
        for (int i = 0; i < 40 && k < 0; i++)
        begin
            @(posedge clk_i);
            #1;
            if (prev && !link.sync_in_pos)
                k = cyc;
            prev = link.sync_in_pos;
        end
    endtask
    task automatic run_cmos(input logic f, input logic t, input logic rs);
        int         k;
        aods_word_t ea, eb;
        if (rs)
        begin
            repeat (10) @(posedge clk_i);
            sreq <= 1'b1;
            @(posedge clk_i);
            sreq <= 1'b0;
        end
        else
            do_reset(f, 1'b0, t, 2);
        wait_sync(k);
        chk_bit(k >= 0, 1'b1, "sync edge");
        repeat (15) @(posedge clk_i);
        #1;
        ea = hist[k] ^ {fmt, 11'h0};
        eb = hist[k + 1] ^ {fmt, 11'h0};
        chk_bit(link.port_a === ea, t, "a at 14");
        if (t)
            chk_bit(link.port_b === eb, 1'b0, "b early");
        @(posedge clk_i);
        #1;
        chk_word(link.port_a, ea, "a at 15");
        chk_word(link.port_b, eb, "b at 15");
        @(posedge clk_i);
        #1;
        chk_word(wa, ea, "capture a");
        chk_word(wb, eb, "capture b");
        $display("cmos test done");
    endtask
    task automatic run_settle;
        chk_bit(fs_lo, 1'b0, "range low");
        @(posedge clk_i);
        craise <= 1'b1;
        fs <= 1'b1;
        @(posedge clk_i);
        craise <= 1'b0;
        #1;
        chk_bit(fs_lo, 1'b1, "range high");
        chk_bit(dcs, 1'b1, "stabilizer on");
        @(posedge clk_i);
        #1;
        chk_bit(valid, 1'b0, "settling");
        repeat (8) @(posedge clk_i);
        #1;
        chk_bit(valid, 1'b1, "valid back");
        $display("settle test done");
    endtask
    task automatic run_lvds;
        int c;
        do_reset(1'b0, 1'b1, 1'b1, 2);
        repeat (20) @(posedge clk_i);
        #1;
        c = cyc - 1;
        chk_word(link.port_a, hist[c - 14], "lvds word");
        chk_bit(link.sync_in_pos, 1'b0, "lvds sync");
        @(posedge clk_i);
        #1;
        chk_word(link.port_a, hist[c - 13], "lvds next");
        $display("lvds test done");
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        hist[cyc] <= sample;
        sample <= sample + 12'h003;
        if (cyc == 1000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        {nrst_i, fmt, std, tim, fs, lvds, sreq, craise} = 8'h00;
        do_reset(1'b0, 1'b0, 1'b1, 20);
        run_cmos(1'b0, 1'b1, 1'b1);
        run_cmos(1'b1, 1'b1, 1'b0);
        run_cmos(1'b1, 1'b0, 1'b0);
        run_cmos(1'b0, 1'b0, 1'b0);
        run_settle();
        run_lvds();
        results();
    end
endmodule
